//--- logic/rsa_pkg.sv
package rsa_pkg;

	localparam int         CLK_FREQ_KHZ    = 250000;
	localparam int         BUS_TIMEOUT_MS  = 1000;
	localparam int         BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * CLK_FREQ_KHZ;
	localparam int         MIN_TIMEOUT_CYC = 16;
	localparam int         SCL_MAX_KHZ     = 400;
	// Arbitrary neutral bus address
	localparam logic [6:0] DEF_DEV_ADDR    = 7'h2A;
	localparam logic [3:0] LAST_BIT        = 4'h7;
	localparam logic [3:0] ACK_SLOT        = 4'h8;
	localparam logic [7:0] PTR_RESET       = 8'h00;
	localparam logic [3:0] BANK_BASIC_HI   = 4'h0;
	localparam logic [3:0] BANK_EXT_HI     = 4'h1;
	localparam logic [1:0] FREQ_SELECT_FIELD_1K         = 2'h1;
	localparam logic [1:0] FREQ_SELECT_FIELD_1HZ        = 2'h2;
	localparam int         DIV_1K_BIT      = 4;
	localparam int         DIV_1HZ_BIT     = 14;

	typedef enum logic [4:0] {
		ST_ADDR  = 5'b00001,
		ST_REG   = 5'b00010,
		ST_WDATA = 5'b00100,
		ST_RDATA = 5'b01000,
		ST_IDLE  = 5'b10000
	} rsa_state_e;

	typedef enum logic [2:0] {
		BANK_BASIC = 3'b001,
		BANK_EXT   = 3'b010,
		BANK_TEST  = 3'b100
	} rsa_bank_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rsa_reg_req_s;

	typedef struct packed {
		logic       fixed_en;
		logic       fixed_val;
		logic [7:0] select;
	} rsa_status_cfg_s;

	function automatic logic [7:0] rsa_ptr_inc(input logic [7:0] p);
		return {p[7:4], p[3:0] + 4'h1};
	endfunction : rsa_ptr_inc

	function automatic rsa_bank_e rsa_bank(input logic [7:0] a);
		if (a[7:4] == BANK_BASIC_HI)
			return BANK_BASIC;
		else if (a[7:4] == BANK_EXT_HI)
			return BANK_EXT;
		else
			return BANK_TEST;
	endfunction : rsa_bank

endpackage : rsa_pkg

//--- logic/rsa_link_engine.sv
`timescale 1ns/1ps
module rsa_link_engine #(
	parameter logic [6:0] DEV_ADDR = rsa_pkg::DEF_DEV_ADDR
) (
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       rst_b_in,
	input  wire logic       link_rst_b_in,
	input  wire logic [7:0] rd_data_in,
	output logic            sda_oe_out,
	output logic            wr_tgl_out,
	output logic            rd_tgl_out,
	output logic [7:0]      ptr_out,
	output logic [7:0]      wr_addr_out,
	output logic [7:0]      wdata_out
);

	rsa_pkg::rsa_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shreg, next_shreg, rx_byte;
	logic       ack, next_ack, next_oe;
	logic [7:0] next_ptr, next_wr_addr, next_wdata;
	logic       next_wr_tgl, next_rd_tgl;

	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_shreg   = shreg;
		next_ack     = ack;
		next_ptr     = ptr_out;
		next_wr_addr = wr_addr_out;
		next_wdata   = wdata_out;
		next_wr_tgl  = wr_tgl_out;
		next_rd_tgl  = rd_tgl_out;
		rx_byte      = {shreg[6:0], sda_in};
		if (cnt == rsa_pkg::ACK_SLOT) begin
			next_cnt = 4'h0;
			next_ack = 1'b0;
			if (state == rsa_pkg::ST_RDATA && !ack) begin
				next_ptr = rsa_pkg::rsa_ptr_inc(ptr_out);
				if (sda_in)
					next_state = rsa_pkg::ST_IDLE;
				else
					next_rd_tgl = ~rd_tgl_out;
			end
		end else begin
			next_cnt   = cnt + 4'h1;
			next_shreg = rx_byte;
			if (cnt == rsa_pkg::LAST_BIT) begin
				case (state)
					rsa_pkg::ST_ADDR: begin
						if (rx_byte[7:1] == DEV_ADDR) begin
							next_ack = 1'b1;
							if (rx_byte[0]) begin
								next_state  = rsa_pkg::ST_RDATA;
								next_rd_tgl = ~rd_tgl_out;
							end else begin
								next_state = rsa_pkg::ST_REG;
							end
						end else begin
							next_state = rsa_pkg::ST_IDLE;
						end
					end
					rsa_pkg::ST_REG: begin
						next_ack   = 1'b1;
						next_ptr   = rx_byte;
						next_state = rsa_pkg::ST_WDATA;
					end
					rsa_pkg::ST_WDATA: begin
						next_ack     = 1'b1;
						next_wr_addr = ptr_out;
						next_wdata   = rx_byte;
						next_wr_tgl  = ~wr_tgl_out;
						next_ptr     = rsa_pkg::rsa_ptr_inc(ptr_out);
					end
					rsa_pkg::ST_RDATA,
					rsa_pkg::ST_IDLE: begin
						next_ack = 1'b0;
					end
					default: begin
						next_state = rsa_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// Frame state dies with every start, stop or timeout
	always_ff @(posedge scl_in or negedge link_rst_b_in) begin
		if (!link_rst_b_in) begin
			state <= rsa_pkg::ST_ADDR;
			cnt   <= 4'h0;
			shreg <= 8'h00;
			ack   <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			shreg <= next_shreg;
			ack   <= next_ack;
		end
	end

	// Pointer survives a repeated start
	always_ff @(posedge scl_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ptr_out     <= rsa_pkg::PTR_RESET;
			wr_addr_out <= 8'h00;
			wdata_out   <= 8'h00;
			wr_tgl_out  <= 1'b0;
			rd_tgl_out  <= 1'b0;
		end else begin
			ptr_out     <= next_ptr;
			wr_addr_out <= next_wr_addr;
			wdata_out   <= next_wdata;
			wr_tgl_out  <= next_wr_tgl;
			rd_tgl_out  <= next_rd_tgl;
		end
	end

	always_comb begin
		if (cnt == rsa_pkg::ACK_SLOT)
			next_oe = ack;
		else if (state == rsa_pkg::ST_RDATA)
			next_oe = ~rd_data_in[3'h7 - cnt[2:0]];
		else
			next_oe = 1'b0;
	end

	// Data changes only while the clock is low
	always_ff @(negedge scl_in or negedge link_rst_b_in) begin
		if (!link_rst_b_in)
			sda_oe_out <= 1'b0;
		else
			sda_oe_out <= next_oe;
	end

	chk_sda_drive_window: assert property (@(posedge scl_in) disable iff (!link_rst_b_in)
		sda_oe_out |-> (cnt == rsa_pkg::ACK_SLOT || state == rsa_pkg::ST_RDATA))
		else $error("data line pulled outside ack or read slot");
	chk_ptr_wrap_nibble: assert property (@(posedge scl_in) disable iff (!rst_b_in)
		$changed(wr_tgl_out) |-> ptr_out == {wr_addr_out[7:4], wr_addr_out[3:0] + 4'h1})
		else $error("pointer did not wrap inside bank");
	chk_nack_ends_read: assert property (@(posedge scl_in) disable iff (!link_rst_b_in)
		(state == rsa_pkg::ST_RDATA && cnt == rsa_pkg::ACK_SLOT && !ack && sda_in) |=> state == rsa_pkg::ST_IDLE)
		else $error("read did not end on host nack");

endmodule : rsa_link_engine

//--- logic/rsa_top.sv
`timescale 1ns/1ps
module rsa_top #(
	parameter int         TIMEOUT_CYCLES = rsa_pkg::BUS_TIMEOUT_CYC,
	parameter logic [6:0] DEV_ADDR       = rsa_pkg::DEF_DEV_ADDR
) (
	input  wire logic                     ref_clk_in,
	input  wire logic                     rst_b_in,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_out,
	input  wire logic                     osc_32k_in,
	input  wire logic                     freq_output_enable_pin_in,
	input  wire logic [1:0]               freq_select_field_in,
	output logic                          freq_output_pin_out,
	output logic                          freq_output_pin_oe_out,
	input  wire logic                     irq_pending_in,
	output logic                          int_n_out,
	output logic                          int_oe_out,
	input  wire logic                     event_trigger_in,
	input  wire logic                     event_rise_sel_in,
	input  wire logic                     event_pullup_en_in,
	output logic                          event_pullup_out,
	output logic                          event_capture_out,
	input  wire logic [7:0]               status_flags_in,
	input  wire rsa_pkg::rsa_status_cfg_s status_cfg_in,
	output logic                          status_out_pin_out,
	input  wire logic [7:0]               reg_rdata_in,
	output rsa_pkg::rsa_reg_req_s         reg_req_out,
	output logic                          reg_bank_ext_out,
	output logic                          reg_test_space_out,
	output logic                          access_active_out,
	output logic                          bus_timeout_out
);

	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	generate
		if (TIMEOUT_CYCLES < rsa_pkg::MIN_TIMEOUT_CYC) begin : g_bad_timeout
			$error("TIMEOUT_CYCLES too small");
		end
	endgenerate

	// Pin and cross-domain synchronisers
	logic [1:0] scl_sy, sda_sy, foe_sy, osc_sy, evt_sy, wr_sy, rd_sy;
	logic       eng_wr_tgl, eng_rd_tgl, eng_sda_oe;
	logic [7:0] eng_ptr, eng_wr_addr, eng_wdata;
	logic [7:0] rd_hold, next_rd_hold;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			foe_sy <= 2'h0;
			osc_sy <= 2'h0;
			evt_sy <= 2'h3;
			wr_sy  <= 2'h0;
			rd_sy  <= 2'h0;
		end else begin
			scl_sy <= {scl_sy[0], scl_in};
			sda_sy <= {sda_sy[0], sda_in};
			foe_sy <= {foe_sy[0], freq_output_enable_pin_in};
			osc_sy <= {osc_sy[0], osc_32k_in};
			evt_sy <= {evt_sy[0], event_trigger_in};
			wr_sy  <= {wr_sy[0], eng_wr_tgl};
			rd_sy  <= {rd_sy[0], eng_rd_tgl};
		end
	end

	// Frame tracking and bus watchdog
	logic          in_frame, next_in_frame;
	logic          link_rst_b, next_link_rst_b;
	logic [TW-1:0] wd_cnt, next_wd_cnt;
	logic          sda_d, next_timeout, start_det, stop_det, wd_hit;

	always_comb begin
		start_det       = scl_sy[1] && sda_d && !sda_sy[1];
		stop_det        = scl_sy[1] && !sda_d && sda_sy[1];
		wd_hit          = in_frame && (wd_cnt == TW'(TIMEOUT_CYCLES - 1));
		next_in_frame   = in_frame;
		if (start_det)
			next_in_frame = 1'b1;
		else if (stop_det || wd_hit)
			next_in_frame = 1'b0;
		next_link_rst_b = in_frame && !start_det && !stop_det && !wd_hit;
		next_wd_cnt     = (!in_frame || start_det) ? '0 : wd_cnt + TW'(1);
		next_timeout    = wd_hit;
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			in_frame        <= 1'b0;
			link_rst_b      <= 1'b0;
			wd_cnt          <= '0;
			sda_d           <= 1'b1;
			bus_timeout_out <= 1'b0;
		end else begin
			in_frame        <= next_in_frame;
			link_rst_b      <= next_link_rst_b;
			wd_cnt          <= next_wd_cnt;
			sda_d           <= sda_sy[1];
			bus_timeout_out <= next_timeout;
		end
	end

	rsa_link_engine #(
		.DEV_ADDR (DEV_ADDR)
	) u_engine (
		.scl_in        (scl_in),
		.sda_in        (sda_in),
		.rst_b_in      (rst_b_in),
		.link_rst_b_in (link_rst_b),
		.rd_data_in    (rd_hold),
		.sda_oe_out    (eng_sda_oe),
		.wr_tgl_out    (eng_wr_tgl),
		.rd_tgl_out    (eng_rd_tgl),
		.ptr_out       (eng_ptr),
		.wr_addr_out   (eng_wr_addr),
		.wdata_out     (eng_wdata)
	);
	assign sda_oe_out = eng_sda_oe;

	// Register-space requests; engine words are stable across each toggle
	rsa_pkg::rsa_reg_req_s next_req;
	logic       wr_d, rd_d, wr_ev, rd_ev, rd_pend, next_rd_pend;
	logic       next_bank_ext, next_test_space, next_active;

	always_comb begin
		wr_ev           = wr_sy[1] ^ wr_d;
		rd_ev           = rd_sy[1] ^ rd_d;
		next_req        = reg_req_out;
		next_req.wr     = wr_ev;
		next_req.rd     = rd_ev && !wr_ev;
		if (wr_ev) begin
			next_req.addr  = eng_wr_addr;
			next_req.wdata = eng_wdata;
		end else if (rd_ev) begin
			next_req.addr = eng_ptr;
		end
		next_rd_pend    = reg_req_out.rd;
		next_rd_hold    = rd_pend ? reg_rdata_in : rd_hold;
		next_bank_ext   = rsa_pkg::rsa_bank(next_req.addr) == rsa_pkg::BANK_EXT;
		next_test_space = rsa_pkg::rsa_bank(next_req.addr) == rsa_pkg::BANK_TEST;
		next_active     = in_frame;
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_d               <= 1'b0;
			rd_d               <= 1'b0;
			reg_req_out        <= '0;
			rd_pend            <= 1'b0;
			rd_hold            <= 8'h00;
			reg_bank_ext_out   <= 1'b0;
			reg_test_space_out <= 1'b0;
			access_active_out  <= 1'b0;
		end else begin
			wr_d               <= wr_sy[1];
			rd_d               <= rd_sy[1];
			reg_req_out        <= next_req;
			rd_pend            <= next_rd_pend;
			rd_hold            <= next_rd_hold;
			reg_bank_ext_out   <= next_bank_ext;
			reg_test_space_out <= next_test_space;
			access_active_out  <= next_active;
		end
	end

	// Sideband pins
	logic        osc_d, evt_d, freq_output_pin_src;
	logic [14:0] div_cnt, next_div_cnt;
	logic        next_freq_output_pin, next_freq_output_pin_oe, next_int_oe, next_cap, next_pullup, next_status;

	always_comb begin
		next_div_cnt = (osc_sy[1] && !osc_d) ? div_cnt + 15'h0001 : div_cnt;
		case (freq_select_field_in)
			rsa_pkg::FREQ_SELECT_FIELD_1K:  freq_output_pin_src = div_cnt[rsa_pkg::DIV_1K_BIT];
			rsa_pkg::FREQ_SELECT_FIELD_1HZ: freq_output_pin_src = div_cnt[rsa_pkg::DIV_1HZ_BIT];
			default:           freq_output_pin_src = osc_sy[1];
		endcase
		next_freq_output_pin    = freq_output_pin_src;
		next_freq_output_pin_oe = foe_sy[1];
		next_int_oe  = irq_pending_in;
		if (event_rise_sel_in)
			next_cap = evt_sy[1] && !evt_d;
		else
			next_cap = !evt_sy[1] && evt_d;
		next_pullup  = event_pullup_en_in;
		if (status_cfg_in.fixed_en)
			next_status = status_cfg_in.fixed_val;
		else
			next_status = |(status_flags_in & status_cfg_in.select);
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			osc_d                  <= 1'b0;
			evt_d                  <= 1'b1;
			div_cnt                <= 15'h0000;
			freq_output_pin_out    <= 1'b0;
			freq_output_pin_oe_out <= 1'b0;
			int_n_out              <= 1'b0;
			int_oe_out             <= 1'b0;
			sda_out                <= 1'b0;
			event_capture_out      <= 1'b0;
			event_pullup_out       <= 1'b0;
			status_out_pin_out     <= 1'b0;
		end else begin
			osc_d                  <= osc_sy[1];
			evt_d                  <= evt_sy[1];
			div_cnt                <= next_div_cnt;
			freq_output_pin_out    <= next_freq_output_pin;
			freq_output_pin_oe_out <= next_freq_output_pin_oe;
			int_n_out              <= 1'b0;
			int_oe_out             <= next_int_oe;
			sda_out                <= 1'b0;
			event_capture_out      <= next_cap;
			event_pullup_out       <= next_pullup;
			status_out_pin_out     <= next_status;
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_start_seen;
		start_det && !wd_hit;
	endsequence
	sequence s_link_pulse;
		!link_rst_b ##1 link_rst_b;
	endsequence

	chk_freq_output_pin_follow_enable: assert property (
		foe_sy[1] ##1 foe_sy[1] |=> freq_output_pin_oe_out [*1])
		else $error("frequency pin not enabled");
	chk_freq_output_pin_hiz_off: assert property (!foe_sy[1] |=> !freq_output_pin_oe_out)
		else $error("frequency pin driven while disabled");
	chk_int_sink_only: assert property (irq_pending_in |=> int_oe_out && !int_n_out)
		else $error("interrupt not pulled low");
	chk_int_release: assert property (!irq_pending_in |=> !int_oe_out)
		else $error("interrupt held after release");
	chk_event_capture_edge: assert property (
		(event_rise_sel_in && evt_sy[1] && !evt_d) |=> event_capture_out)
		else $error("event edge missed");
	chk_status_fixed_level: assert property (
		status_cfg_in.fixed_en |=> status_out_pin_out == $past(status_cfg_in.fixed_val))
		else $error("status pin not at fixed level");
	chk_timeout_link_reset: assert property (wd_hit |=> !link_rst_b && !in_frame && bus_timeout_out)
		else $error("watchdog did not reset link");
	chk_start_link_pulse: assert property (s_start_seen |=> s_link_pulse)
		else $error("start did not restart link");
	chk_write_strobe_addr: assert property (
		wr_ev |=> reg_req_out.wr && reg_req_out.addr == $past(eng_wr_addr) && !reg_req_out.rd)
		else $error("write strobe wrong");
	chk_bank_ext_decode: assert property (
		(reg_req_out.wr || reg_req_out.rd) |-> reg_bank_ext_out == (reg_req_out.addr[7:4] == 4'h1))
		else $error("bank decode wrong");

endmodule : rsa_top

//--- verif/rsa_i2c_host.sv
`timescale 1ns/1ps
// Bus host; only pulls the data line low or lets the pull-up win
module rsa_i2c_host (
	output logic      scl_out,
	output logic      pull_out,
	input  wire logic sda_in
);
	localparam realtime Q = 31.25;

	initial begin
		scl_out = 1'b1;
		pull_out = 1'b0;
	end

	task automatic start();
		pull_out = 1'b0;
		#(2*Q) scl_out = 1'b1;
		#(2*Q) pull_out = 1'b1;
		// Leaves the start sync time before the first clock
		#(4*Q) scl_out = 1'b0;
	endtask : start

	task automatic stop();
		#Q pull_out = 1'b1;
		#Q scl_out = 1'b1;
		#(2*Q) pull_out = 1'b0;
		#(4*Q);
	endtask : stop

	// Data moves only while the clock is low
	task automatic bit_io(input logic d, output logic s);
		#Q pull_out = ~d;
		#Q scl_out = 1'b1;
		s = sda_in;
		#(2*Q) scl_out = 1'b0;
	endtask : bit_io

	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack_in, ack);
	endtask : xfer
endmodule : rsa_i2c_host

//--- verif/rtc_serial_register_access_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rtc_serial_register_access_bench;
	localparam int         TMO = 2000;
	localparam logic [6:0] ADR = rsa_pkg::DEF_DEV_ADDR;
	logic clk, rst_b, osc, freq_output_enable_pin, irq, evt, rsel, pu_en, ext_seen, tst_seen;
	logic scl, pull, sda, sda_o, sda_oe, fpin, fpin_oe, fpin_d;
	logic int_n, int_oe, pu, evc, status_out_pin, ext, tst, act, tmo;
	logic [1:0]                freq_select_field;
	logic [7:0]                flags, rdata;
	logic [7:0]                mem [256];
	rsa_pkg::rsa_status_cfg_s scfg;
	rsa_pkg::rsa_reg_req_s    req;
	int error_cnt, comparisons, cyc, tmo_cnt, ev_cnt, rise_cnt;

	// Open-drain wire with pull-up
	assign sda = ~(pull | sda_oe);

	rsa_i2c_host host (.scl_out(scl), .pull_out(pull), .sda_in(sda));

	rsa_top #(.TIMEOUT_CYCLES(TMO)) DUT (
		.ref_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .osc_32k_in(osc),
		.freq_output_enable_pin_in(freq_output_enable_pin), .freq_select_field_in(freq_select_field),
		.freq_output_pin_out(fpin), .freq_output_pin_oe_out(fpin_oe),
		.irq_pending_in(irq), .int_n_out(int_n), .int_oe_out(int_oe),
		.event_trigger_in(evt), .event_rise_sel_in(rsel),
		.event_pullup_en_in(pu_en), .event_pullup_out(pu), .event_capture_out(evc),
		.status_flags_in(flags), .status_cfg_in(scfg), .status_out_pin_out(status_out_pin),
		.reg_rdata_in(rdata), .reg_req_out(req), .reg_bank_ext_out(ext),
		.reg_test_space_out(tst), .access_active_out(act), .bus_timeout_out(tmo)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Stand-in oscillator, much faster than the real one to keep runs short
	initial begin
		osc = 1'b0;
		forever #100 osc = ~osc;
	end

	// Register file behind the block; read data lands one cycle after rd
	always @(posedge clk) begin
		cyc++;
		fpin_d <= fpin;
		if (fpin && !fpin_d) rise_cnt++;
		if (tmo) tmo_cnt++;
		if (evc) ev_cnt++;
		if (req.wr) mem[req.addr] <= req.wdata;
		if (req.wr || req.rd) ext_seen <= ext;
		if (req.wr || req.rd) tst_seen <= tst;
		if (req.rd) rdata <= mem[req.addr];
		if (sda_oe) `CHK(sda_o, 1'b0)
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task automatic wclk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wclk

	task automatic t_write();
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer({ADR, 1'b0}, 1'b1, q, a);
		`CHK(a, 1'b0)
		host.xfer(8'h0E, 1'b1, q, a);
		for (int k = 0; k < 3; k++)
			host.xfer(8'hA0 + 8'(k), 1'b1, q, a);
		host.stop();
		for (int k = 0; k < 3; k++)
			`CHK(mem[{4'h0, 4'(14 + k)}], 8'hA0 + 8'(k))
		`CHK(ext_seen, 1'b0)
		`CHK(tst_seen, 1'b0)
	endtask : t_write

	task automatic t_read();
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer({ADR, 1'b0}, 1'b1, q, a);
		host.xfer(8'h1F, 1'b1, q, a);
		host.start();
		host.xfer({ADR, 1'b1}, 1'b1, q, a);
		`CHK(a, 1'b0)
		host.xfer(8'hFF, 1'b0, q, a);
		`CHK(q, 8'h1F ^ 8'h5A)
		host.xfer(8'hFF, 1'b1, q, a);
		`CHK(q, 8'h10 ^ 8'h5A)
		host.stop();
		`CHK(ext_seen, 1'b1)
		`CHK(tst_seen, 1'b0)
	endtask : t_read

	task automatic t_badaddr();
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, q, a);
		`CHK(a, 1'b1)
		host.stop();
	endtask : t_badaddr

	task automatic t_timeout();
		logic [7:0] q;
		logic a;
		tmo_cnt = 0;
		host.start();
		host.xfer({ADR, 1'b0}, 1'b1, q, a);
		`CHK(act, 1'b1)
		// Host stalls with the clock low
		wclk(TMO + 200);
		`CHK(tmo_cnt, 1)
		`CHK(sda_oe, 1'b0)
		`CHK(act, 1'b0)
		host.stop();
	endtask : t_timeout

	task automatic t_freq();
		freq_output_enable_pin = 1'b0;
		wclk(8);
		`CHK(fpin_oe, 1'b0)
		freq_output_enable_pin = 1'b1;
		for (int m = 0; m < 4; m += 3) begin
			wclk(1);
			freq_select_field = 2'(m);
			wclk(8);
			`CHK(fpin_oe, 1'b1)
			@(posedge osc);
			#61;
			`CHK(fpin, 1'b1)
			@(negedge osc);
			#61;
			`CHK(fpin, 1'b0)
		end
		wclk(1);
		freq_select_field = 2'h1;
		repeat (2) @(posedge osc);
		#61;
		rise_cnt = 0;
		repeat (64) @(posedge osc);
		#61;
		`CHK(rise_cnt, 2)
	endtask : t_freq

	task automatic t_irq();
		wclk(1);
		irq = 1'b1;
		wclk(3);
		`CHK(int_oe, 1'b1)
		`CHK(int_n, 1'b0)
		irq = 1'b0;
		wclk(3);
		`CHK(int_oe, 1'b0)
	endtask : t_irq

	task automatic t_event();
		pu_en = 1'b1;
		wclk(4);
		`CHK(pu, 1'b1)
		pu_en = 1'b0;
		wclk(4);
		`CHK(pu, 1'b0)
		ev_cnt = 0;
		for (int s = 1; s >= 0; s--) begin
			rsel = s[0];
			evt = 1'b1;
			wclk(6);
			evt = 1'b0;
			wclk(6);
			`CHK(ev_cnt, 2 - s)
		end
	endtask : t_event

	task automatic t_status();
		logic [9:0] cfg [4];
		cfg = '{10'h300, 10'h204, 10'h004, 10'h108};
		flags = 8'h04;
		for (int i = 0; i < 4; i++) begin
			scfg = cfg[i];
			wclk(3);
			`CHK(status_out_pin, ~i[0])
		end
	endtask : t_status

	initial begin
		rst_b = 1'b0;
		freq_output_enable_pin = 1'b0;
		freq_select_field = 2'h0;
		irq = 1'b0;
		evt = 1'b0;
		rsel = 1'b1;
		pu_en = 1'b0;
		flags = 8'h00;
		scfg = '0;
		rdata = 8'h00;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		wclk(16);
		rst_b = 1'b1;
		wclk(3);
		t_write();
		t_read();
		t_badaddr();
		t_timeout();
		t_freq();
		t_irq();
		t_event();
		t_status();
		report_and_stop();
	end
endmodule : rtc_serial_register_access_bench
